// file: rtl/lane_training_trigger.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module lane_training_trigger (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [3:0] trainingRestartRequest,
  output logic [3:0] partnerCoefUpdateRequest,
  output logic [3:0] localCoefLoadRequest,
  output logic partnerCoefOverrideEnable,
  output logic localCoefOverrideEnable
);
  // ----------------------------------------
  // write channel state
  // ----------------------------------------
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
  logic [11:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic [1:0] bresp_q, bresp_d;
  logic [3:0] restart_q, restart_d, partner_q, partner_d;
  logic [3:0] local_q, local_d;
  logic pOvrd_q, pOvrd_d, lOvrd_q, lOvrd_d;
  logic doWrite;
  logic awReady_q, awReady_d, wReady_q, wReady_d;

  // decode of a word address
  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a[11:2] == lane_training_pkg::CTRL_ADDR[11:2]) ||
               (a[11:2] == lane_training_pkg::OVRD_ADDR[11:2]);
  endfunction : isMapped

  // write takes both halves, then answers once
  always_comb begin
    awHeld_d = awHeld_q;
    wHeld_d = wHeld_q;
    awAddr_d = awAddr_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    restart_d = 4'h0; // pulses last one cycle [R15] [R14]
    partner_d = 4'h0;
    local_d = 4'h0;
    pOvrd_d = pOvrd_q;
    lOvrd_d = lOvrd_q;
    doWrite = awHeld_q && wHeld_q && !bvalid_q;
    if (awvalid && !awHeld_q) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && !wHeld_q) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    if (doWrite) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = isMapped(awAddr_q) ? lane_training_pkg::RESP_OKAY
                                   : lane_training_pkg::RESP_SLVERR;
      if (awAddr_q[11:2] == lane_training_pkg::CTRL_ADDR[11:2]) begin
        if (wStrb_q[0]) begin
          // only written ones fire [R1] [R2] [R3] [R14]
          restart_d = wData_q[lane_training_pkg::RESTART_LSB +: 4];
          // gated by partner override [R4] [R5] [R6] [R12]
          partner_d = pOvrd_q ?
            wData_q[lane_training_pkg::PARTNER_LSB +: 4] : 4'h0;
        end
        if (wStrb_q[1]) begin
          // gated by local override [R7] [R8] [R9] [R10] [R11] [R13]
          local_d = lOvrd_q ?
            wData_q[lane_training_pkg::LOCAL_LSB +: 4] : 4'h0;
        end
      end
      if (awAddr_q[11:2] == lane_training_pkg::OVRD_ADDR[11:2] &&
          wStrb_q[2]) begin
        pOvrd_d = wData_q[lane_training_pkg::PARTNER_OVRD_BIT];
        lOvrd_d = wData_q[lane_training_pkg::LOCAL_OVRD_BIT];
      end
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    // ready flags are registered copies of the free state
    awReady_d = !awHeld_d;
    wReady_d = !wHeld_d;
  end

  // write registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      restart_q <= 4'h0;
      partner_q <= 4'h0;
      local_q <= 4'h0;
      pOvrd_q <= 1'b0;
      lOvrd_q <= 1'b0;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      awAddr_q <= awAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      restart_q <= restart_d;
      partner_q <= partner_d;
      local_q <= local_d;
      pOvrd_q <= pOvrd_d;
      lOvrd_q <= lOvrd_d;
      awReady_q <= awReady_d;
      wReady_q <= wReady_d;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic arReady_q, arReady_d;

  // triggers always read as zero [R15]
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdata_d = 32'h00000000;
      rresp_d = isMapped(araddr) ? lane_training_pkg::RESP_OKAY
                                 : lane_training_pkg::RESP_SLVERR;
      if (araddr[11:2] == lane_training_pkg::OVRD_ADDR[11:2]) begin
        rdata_d[lane_training_pkg::PARTNER_OVRD_BIT] = pOvrd_q;
        rdata_d[lane_training_pkg::LOCAL_OVRD_BIT] = lOvrd_q;
      end
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    // free for a new address once the answer is gone
    arReady_d = !rvalid_d;
  end

  // read registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'h0;
      arReady_q <= 1'b1;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arReady_q <= arReady_d;
    end
  end

  // outputs
  assign awready = awReady_q;
  assign wready = wReady_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arReady_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign trainingRestartRequest = restart_q;
  assign partnerCoefUpdateRequest = partner_q;
  assign localCoefLoadRequest = local_q;
  assign partnerCoefOverrideEnable = pOvrd_q;
  assign localCoefOverrideEnable = lOvrd_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic ctrlHit;
  assign ctrlHit = doWrite && wStrb_q[0] &&
    awAddr_q[11:2] == lane_training_pkg::CTRL_ADDR[11:2];
  logic localHit, ovrdHit;
  assign localHit = doWrite && wStrb_q[1] &&
    awAddr_q[11:2] == lane_training_pkg::CTRL_ADDR[11:2];
  assign ovrdHit = doWrite && wStrb_q[2] &&
    awAddr_q[11:2] == lane_training_pkg::OVRD_ADDR[11:2];

  property p_restart;
    ctrlHit && wData_q[1] |=> trainingRestartRequest[1];
  endproperty
  a_restart: assert property (p_restart) else $error("restart lost"); // [R1]
  property p_restart0;
    ctrlHit && wData_q[0] |=> trainingRestartRequest[0];
  endproperty
  a_restart0: assert property (p_restart0) else $error("lane0 lost"); // [R2]
  property p_restart23;
    ctrlHit |=> trainingRestartRequest[3:2] == $past(wData_q[3:2]);
  endproperty
  a_restart23: assert property (p_restart23) else $error("lane2/3"); // [R3]
  property p_partner_gate;
    partnerCoefUpdateRequest != 4'h0 |-> $past(pOvrd_q);
  endproperty
  a_partner_gate: assert property (p_partner_gate) // [R5]
    else $error("partner without override");
  property p_partner;
    ctrlHit && pOvrd_q |=> partnerCoefUpdateRequest == $past(wData_q[7:4]);
  endproperty
  a_partner: assert property (p_partner) else $error("partner fire"); // [R6]
  property p_local_gate;
    localCoefLoadRequest != 4'h0 |-> $past(lOvrd_q);
  endproperty
  a_local_gate: assert property (p_local_gate) // [R8]
    else $error("local without override");
  property p_pulse;
    trainingRestartRequest[1] |=> !trainingRestartRequest[1];
  endproperty
  a_pulse: assert property (p_pulse) else $error("not a pulse"); // [R15]
  property p_noread;
    rvalid && $rose(rvalid) && rdata[15:0] != 16'h0000 |-> 1'b0;
  endproperty
  a_noread: assert property (p_noread) else $error("trigger read 1"); // [R14]
  c_restart: cover property (trainingRestartRequest[1]);
  c_partner: cover property (partnerCoefUpdateRequest[1]);
  c_local: cover property (localCoefLoadRequest[2]);
  c_slverr: cover property (bvalid &&
    bresp == lane_training_pkg::RESP_SLVERR);
  c_ovrd: cover property ($rose(partnerCoefOverrideEnable));

  // per-lane source of every request pulse, local firing and one-cycle width
  for (genvar g = 0; g < lane_training_pkg::LANES; g++) begin : g_lane
    property p_restart_src;
      trainingRestartRequest[g] |-> $past(ctrlHit && wData_q[g]);
    endproperty
    a_restart_src: assert property (p_restart_src) // [R14]
      else $error("restart without written one");
    property p_partner_src;
      partnerCoefUpdateRequest[g] |-> $past(ctrlHit && pOvrd_q &&
        wData_q[lane_training_pkg::PARTNER_LSB + g]);
    endproperty
    a_partner_src: assert property (p_partner_src) // [R4] [R6] [R12]
      else $error("partner pulse without trigger");
    property p_local_fire;
      localHit && lOvrd_q && wData_q[lane_training_pkg::LOCAL_LSB + g] |=>
        localCoefLoadRequest[g];
    endproperty
    a_local_fire: assert property (p_local_fire) // [R7] [R9] [R10] [R11]
      else $error("local trigger lost");
    property p_local_src;
      localCoefLoadRequest[g] |-> $past(localHit && lOvrd_q &&
        wData_q[lane_training_pkg::LOCAL_LSB + g]);
    endproperty
    a_local_src: assert property (p_local_src) // [R13]
      else $error("local pulse without trigger");
    property p_lane_pulse;
      (trainingRestartRequest[g] || partnerCoefUpdateRequest[g] ||
        localCoefLoadRequest[g]) |=> !(trainingRestartRequest[g] ||
        partnerCoefUpdateRequest[g] || localCoefLoadRequest[g]);
    endproperty
    a_lane_pulse: assert property (p_lane_pulse) // [R15]
      else $error("request longer than a cycle");
  end

  // override enables move only on a write to their word
  property p_ovrd_hold;
    !ovrdHit |=> $stable({partnerCoefOverrideEnable,
      localCoefOverrideEnable});
  endproperty
  a_ovrd_hold: assert property (p_ovrd_hold) // [R12] [R13]
    else $error("override enable moved");
  property p_partner_ovrd;
    ovrdHit |=> partnerCoefOverrideEnable ==
      $past(wData_q[lane_training_pkg::PARTNER_OVRD_BIT]);
  endproperty
  a_partner_ovrd: assert property (p_partner_ovrd) // [R12]
    else $error("partner enable not loaded");
  property p_local_ovrd;
    ovrdHit |=> localCoefOverrideEnable ==
      $past(wData_q[lane_training_pkg::LOCAL_OVRD_BIT]);
  endproperty
  a_local_ovrd: assert property (p_local_ovrd) // [R13]
    else $error("local enable not loaded");

  // no trigger bit is ever read back, an unmapped write fires nothing
  property p_read_low;
    rvalid |-> rdata[15:0] == 16'h0000;
  endproperty
  a_read_low: assert property (p_read_low) // [R14]
    else $error("trigger bit read back");
  property p_unmapped;
    doWrite && !isMapped(awAddr_q) |=> {trainingRestartRequest,
      partnerCoefUpdateRequest, localCoefLoadRequest} == 12'h000;
  endproperty
  a_unmapped: assert property (p_unmapped) // [R14]
    else $error("unmapped write fired");
endmodule : lane_training_trigger
`default_nettype wire

// file: shared/lane_training_pkg.sv
// Functional notes
// [R1] A 1 written to bit 1 restarts lane 1 training and the bit self-clears; 0 does nothing.
// [R2] Bit 0 is the same restart trigger for lane 0.
// [R3] Bits 2 and 3 are the same restart trigger for lanes 2 and 3.
// [R4] A 1 written to bit 5 makes lane 1 send partner coefficient updates, then self-clears.
// [R5] Partner coefficient triggers act only while the partner override enable is 1.
// [R6] Bits 4, 6 and 7 are the partner coefficient triggers for lanes 0, 2 and 3.
// [R7] A 1 written to bit 9 makes lane 1 load its local transmit coefficients, then self-clears.
// [R8] Local coefficient triggers act only while the local override enable is 1.
// [R9] Bit 10 is the local coefficient trigger for lane 2.
// [R10] Bit 8 is the local coefficient trigger for lane 0.
// [R11] Bit 11 is the local coefficient trigger for lane 3.
// [R12] Partner override enable set means software commands replace the engine's choice.
// [R13] Local override enable set means software sets local coefficients, else the partner does.
// [R14] Triggers read 0 after reset and a written 0 causes no action.
// [R15] Each trigger gives a one-cycle request pulse and reads back 0 once it is issued.
`default_nettype none
package lane_training_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] CTRL_INDEX = 12'h0d1;
  localparam logic [11:0] CTRL_ADDR = 12'h344;
  localparam logic [11:0] OVRD_ADDR = 12'h340;
  localparam int ADDR_W = 12;
  localparam int LANES = 4;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RESTART_LSB = 0;
  localparam int PARTNER_LSB = 4;
  localparam int LOCAL_LSB = 8;
  localparam int PARTNER_OVRD_BIT = 16;
  localparam int LOCAL_OVRD_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lane_training_pkg
`default_nettype wire

// file: verification/lane_training_trigger_tb.sv
`timescale 1ns/100ps
`default_nettype none
module lane_training_trigger_tb;
  logic clk = 1'b0, rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, seed = 32'hafd0dbee, rd;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, penQ, lenQ;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] trq, pcq, lcq;
  logic [31:0] rdata;
  logic [11:0] expQ[$];
  int bad_count = 0, check_count = 0;
  localparam logic [11:0] CTRL = lane_training_pkg::CTRL_ADDR;
  localparam logic [11:0] OVRD = lane_training_pkg::OVRD_ADDR;
  always #4 clk = ~clk;
  lane_training_trigger dut (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .trainingRestartRequest(trq),
    .partnerCoefUpdateRequest(pcq), .localCoefLoadRequest(lcq),
    .partnerCoefOverrideEnable(penQ), .localCoefOverrideEnable(lenQ));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, s);
    check_count++;
    if (e !== s) begin
      $display("MISMATCH %s exp %h got %h", nm, e, s);
      bad_count++;
    end
  endtask : chk
  task automatic stall();
    bad_count++;
    wrap_up();
  endtask : stall
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  logic pen = 1'b0, len = 1'b0;
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ad, wd;
    logic [11:0] note;
    ad = 1'b0;
    wd = 1'b0;
    // gated pulses expected from the enables before this write
    note = {d[3:0], d[7:4] & {4{pen}}, d[11:8] & {4{len}}};
    if (a == CTRL && note != 12'h000) expQ.push_back(note);
    if (a == lane_training_pkg::OVRD_ADDR) {len, pen} = d[17:16];
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 40 && !(ad && wd); n++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    if (!(ad && wd)) stall();
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (bvalid === 1'b1) break;
    end
    if (n == 40) stall();
    rsp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rdx(input logic [11:0] a);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 40) stall();
    rd = rdata;
    rsp = rresp;
    arvalid <= 1'b0; rready <= 1'b0;
    @(posedge clk);
  endtask : rdx
  // ----------------------------------------
  // pulse monitor: one note per pulse cycle
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst && {trq, pcq, lcq} !== 12'h0) begin
      if (expQ.size() == 0) begin
        chk("spare pulse", 32'h0, {trq, pcq, lcq});
      end else begin
        chk("pulses", expQ.pop_front(), {trq, pcq, lcq});
      end
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdx(OVRD);
    chk("ovrd reset", 32'h0, rd);
    rdx(CTRL);
    chk("ctrl reset", 32'h0, rd);
    wr(CTRL, 32'hfff);
    chk("bresp", lane_training_pkg::RESP_OKAY, rsp);
    wr(OVRD, 32'h30000);
    chk("enables", 2'h3, {lenQ, penQ});
    rdx(OVRD);
    chk("ovrd read", 32'h30000, rd);
    chk("ovrd rresp", lane_training_pkg::RESP_OKAY, rsp);
    // walk one bit at a time with both enables on
    for (int b = 0; b < 12; b++) begin
      wr(CTRL, 32'h1 << b);
    end
    wr(CTRL, 32'h0);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(OVRD, {14'h0, seed[17:16], 16'h0});
      seed = lfsr(seed);
      wr(CTRL, {20'h0, seed[11:0]});
    end
    rdx(CTRL);
    chk("ctrl after", 32'h0, rd);
    wr(12'h100, 32'hfff);
    chk("unmapped bresp", lane_training_pkg::RESP_SLVERR, rsp);
    rdx(12'h100);
    chk("unmapped rresp", lane_training_pkg::RESP_SLVERR, rsp);
    chk("unmapped rdata", 32'h0, rd);
    repeat (4) @(posedge clk);
    chk("notes left", 32'h0, expQ.size());
    wrap_up();
  end
endmodule : lane_training_trigger_tb
`default_nettype wire
